// file: verif/osc_model.sv
`timescale 1ns/1ns
// free-running secondary oscillator facing the clock unit
module osc_model #(
  parameter int HALF_NS = 1000  // half period, faster than a crystal to keep runs short
) (
  output logic oscClk  // oscillator level
);
  // the crystal never stops, device reset or not
  initial oscClk = 1'b0;
  always #HALF_NS oscClk = ~oscClk;
endmodule : osc_model

// file: verif/tb_top.sv
`timescale 1ns/1ns
// self-checking bench for the calendar clock unit
module tb_top;
  localparam int         SEC = 1280;  // sys_clk cycles per counted second
  localparam logic [2:0] CF  = rtc_pkg::ADDR_CONFIG;
  localparam logic [2:0] PD  = rtc_pkg::ADDR_PAD;
  localparam logic [2:0] AC  = rtc_pkg::ADDR_ALCFG;
  localparam logic [2:0] TW  = rtc_pkg::ADDR_TIMEWIN;
  localparam logic [2:0] AW  = rtc_pkg::ADDR_ALRMWIN;
  logic        sys_clk, nrst, extRstN, oscClk, wr, rd, rtcPinOut, rtcPinOe, alarmEventFlag;
  logic [2:0]  addr;
  logic [1:0]  byteEn;
  logic [15:0] wdata, rdata, v;
  int          miscompares, compares, events;

  calendar_clock_unit #(.PRESCALE(64)) i_dut (.sys_clk(sys_clk), .nrst(nrst),
    .extRstN(extRstN), .oscClk(oscClk), .addr(addr), .wdata(wdata), .byteEn(byteEn),
    .wr(wr), .rd(rd), .rdata(rdata), .rtcPinOut(rtcPinOut), .rtcPinOe(rtcPinOe),
    .alarmEventFlag(alarmEventFlag));
  osc_model i_osc (.oscClk(oscClk));

  // clock and alarm pulse counter
  always #50 sys_clk = ~sys_clk;
  always @(negedge sys_clk) if (alarmEventFlag === 1'b1) events = events + 1;

  // compare one value
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    compares++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // one write cycle
  task automatic bw(input logic [2:0] a, input logic [15:0] d, input logic [1:0] b);
    @(posedge sys_clk);
    addr   <= a;
    wdata  <= d;
    byteEn <= b;
    wr     <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask : bw

  // one read cycle, data taken in the following cycle, masked and compared
  task automatic rc(input logic [2:0] a, input logic [15:0] m, input logic [15:0] e,
                    input string n);
    @(posedge sys_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    @(negedge sys_clk);
    chk(n, rdata & m, e);
  endtask : rc

  // fill a window from the year pair downward
  task automatic load(input logic [2:0] a, input logic [2:0] c, input logic [15:0] cv,
                      input logic [3:0][15:0] w);
    bw(c, cv, 2'h3);
    for (int i = 3; i >= 0; i--) bw(a, w[i], 2'h3);
  endtask : load

  // read a window back from the year pair downward
  task automatic verify(input logic [2:0] a, input logic [2:0] c, input logic [15:0] cv,
                        input logic [3:0][15:0] e, input string n);
    bw(c, cv, 2'h3);
    for (int i = 3; i >= 0; i--) rc(a, 16'hFFFF, e[i], n);
    rc(a, 16'hFFFF, e[0], n);
    rc(c, 16'h0300, 16'h0000, "pointer");
  endtask : verify

  // reset values and unmapped places
  task automatic t_reset;
    chk("pin", {14'h0, rtcPinOe, rtcPinOut}, 16'h0000);
    rc(CF, 16'hE7FF, 16'h0000, "config");
    rc(AC, 16'hFFFF, 16'h0000, "alarm config");
    bw(3'h7, 16'hFFFF, 2'h3);
    rc(3'h7, 16'hFFFF, 16'h0000, "unmapped");
    $display("done reset");
  endtask : t_reset

  // one second across a boundary
  task automatic t_roll(input logic [3:0][15:0] w, input logic [3:0][15:0] e);
    load(TW, CF, 16'hA300, w);
    repeat (SEC + 200) @(posedge sys_clk);
    verify(TW, CF, 16'hA300, e, "time");
    $display("done rollover");
  endtask : t_roll

  // locked writes and lane-dependent pointer steps
  task automatic t_lock;
    bw(CF, 16'h8100, 2'h3);
    bw(TW, 16'h0505, 2'h1);
    rc(CF, 16'h0300, 16'h0100, "ptr lower");
    bw(TW, 16'h0505, 2'h2);
    rc(CF, 16'h0300, 16'h0000, "ptr upper");
    bw(CF, 16'hA100, 2'h3);
    rc(TW, 16'hFFFF, 16'h0400, "locked");
    bw(CF, 16'hA100, 2'h3);
    bw(TW, 16'h0007, 2'h1);
    rc(CF, 16'h0300, 16'h0100, "ptr kept");
    rc(TW, 16'hFFFF, 16'h0407, "hour");
    $display("done lock");
  endtask : t_lock

  // counting goes on while the device reset pin is low
  task automatic t_extrst;
    bw(CF, 16'hA000, 2'h3);
    bw(TW, 16'h0010, 2'h1);
    @(posedge sys_clk);
    extRstN <= 1'b0;
    rc(CF, 16'hFFFF, 16'h0000, "blocked read");
    repeat (2 * SEC + 500) @(posedge sys_clk);
    extRstN <= 1'b1;
    rc(TW, 16'h00FF, 16'h0012, "seconds");
    $display("done external reset");
  endtask : t_extrst

  // pin sources, alarm repeat and chime
  task automatic t_pin_alarm;
    logic s0, s1, p;
    s0 = 1'b0;
    s1 = 1'b0;
    bw(PD, 16'h0002, 2'h3);
    bw(CF, 16'hA400, 2'h3);
    repeat (SEC + 100) begin
      @(negedge sys_clk);
      if (rtcPinOut === 1'b1) s1 = 1'b1;
      if (rtcPinOut === 1'b0) s0 = 1'b1;
    end
    chk("second clock pin", {14'h0, s1, s0}, 16'h0003);
    bw(PD, 16'h0000, 2'h3);
    @(negedge sys_clk);
    p = rtcPinOut;
    events = 0;
    bw(AC, 16'hC400, 2'h3);
    for (int k = 0; k < SEC + 100 && events == 0; k++) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("alarm pin", {15'h0, rtcPinOut}, {15'h0, ~p});
    rc(AC, 16'hFFFF, 16'hC4FF, "chime wrap");
    events = 0;
    bw(AC, 16'h8401, 2'h3);
    repeat (3 * SEC + 300) @(posedge sys_clk);
    chk("events", 16'(events), 16'h0002);
    rc(AC, 16'hFFFF, 16'h0400, "enable cleared");
    bw(CF, 16'hA000, 2'h3);
    @(negedge sys_clk);
    chk("pin off", {14'h0, rtcPinOe, rtcPinOut}, 16'h0000);
    $display("done pin and alarm");
  endtask : t_pin_alarm

  // alarm fires only on the tick where seconds match the alarm seconds
  task automatic t_match;
    bw(TW, 16'h0057, 2'h1);
    events = 0;
    bw(AC, 16'h8C00, 2'h3);
    repeat (SEC + 100) @(posedge sys_clk);
    chk("no match", 16'(events), 16'h0000);
    repeat (SEC) @(posedge sys_clk);
    chk("match", 16'(events), 16'h0001);
    rc(AC, 16'h8000, 16'h0000, "match disables");
    $display("done alarm match");
  endtask : t_match

  // verdict and end of run
  task automatic stop_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  // main sequence
  initial begin
    {sys_clk, nrst, wr, rd, addr, wdata, byteEn} = '0;
    {miscompares, compares, events} = '0;
    extRstN = 1'b1;
    repeat (12) @(posedge sys_clk);
    nrst <= 1'b1;
    t_reset;
    bw(CF, 16'h2000, 2'h3);
    bw(CF, 16'hA000, 2'h3);
    t_roll({16'h0024, 16'h0228, 16'h0623, 16'h5959}, {16'h0024, 16'h0229, 16'h0000, 16'h0000});
    t_roll({16'h0099, 16'h1231, 16'h0323, 16'h5959}, {16'h0000, 16'h0101, 16'h0400, 16'h0000});
    t_lock;
    load(AW, AC, 16'h0300, {16'h0099, 16'h1231, 16'h0623, 16'h5958});
    verify(AW, AC, 16'h0300, {16'h0099, 16'h1231, 16'h0623, 16'h5958}, "alarm");
    t_extrst;
    t_pin_alarm;
    t_match;
    stop_test;
  end

  // watchdog against a hang
  initial begin
    repeat (40000) @(posedge sys_clk);
    miscompares++;
    $display("ERROR watchdog expected done seen timeout");
    stop_test;
  end
endmodule : tb_top

// file: verilog/calendar_clock_unit.sv
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/1ns
// BCD time and calendar with alarm, reached through pointer windows
module calendar_clock_unit #(
  parameter int PRESCALE = rtc_pkg::PRESCALE_EDGES  // oscillator edges per second
) (
  input  wire logic        sys_clk,         // system clock, 10 MHz
  input  wire logic        nrst,            // power-on reset, active low
  input  wire logic        extRstN,         // external reset pin, active low
  input  wire logic        oscClk,          // secondary oscillator level
  input  wire logic [2:0]  addr,            // register index
  input  wire logic [15:0] wdata,           // write data
  input  wire logic [1:0]  byteEn,          // write lanes, bit 1 upper
  input  wire logic        wr,              // write strobe
  input  wire logic        rd,              // read strobe
  output logic      [15:0] rdata,           // read data, cycle after rd
  output logic             rtcPinOut,       // clock output pin level
  output logic             rtcPinOe,        // clock output pin enable
  output logic             alarmEventFlag   // alarm event pulse
);
  rtc_pkg::time_s timeReg;
  rtc_pkg::time_s next_timeReg;
  rtc_pkg::time_s alarmReg;
  rtc_pkg::time_s next_alarmReg;
  logic [15:0]    cfg;
  logic [15:0]    next_cfg;
  logic           srcSel;
  logic           next_srcSel;
  logic [15:0]    alCfg;
  logic [15:0]    next_alCfg;
  logic [15:0]    next_rdata;
  logic           alarmToggle;
  logic           next_alarmToggle;
  logic           next_alarmEventFlag;
  logic           secTick;
  logic           halfTick;
  logic           halfSec;
  logic           warn;
  logic           wrOk;
  logic           rdOk;
  logic           timeWrite;
  logic           clearSecond;
  logic           match;
  logic           alarmEvent;
  logic [1:0]     tptr;
  logic [1:0]     aptr;
  logic [3:0]     amask;
  logic [7:0]     rpt;

  assign tptr  = cfg[rtc_pkg::PTR_HI:rtc_pkg::PTR_LO];
  assign aptr  = alCfg[rtc_pkg::PTR_HI:rtc_pkg::PTR_LO];
  assign amask = alCfg[rtc_pkg::AL_MASK_HI:rtc_pkg::AL_MASK_LO];
  assign rpt   = alCfg[7:0];

  // bus is quiet while the device sits in external reset
  assign wrOk = wr && extRstN;
  assign rdOk = rd && extRstN;
  assign timeWrite = wrOk && addr == rtc_pkg::ADDR_TIMEWIN && cfg[rtc_pkg::CFG_UNLOCK];
  assign clearSecond = timeWrite && byteEn[0] && tptr == rtc_pkg::PTR_MINSEC;

  // oscillator divider, kept on the power-on reset only
  rtc_prescaler #(
    .PRESCALE (PRESCALE)
  ) u_prescaler (
    .sys_clk  (sys_clk),
    .nrst     (nrst),
    .oscClk   (oscClk),
    .run      (cfg[rtc_pkg::CFG_EN]),
    .clear    (clearSecond),
    .secTick  (secTick),
    .halfTick (halfTick),
    .halfSec  (halfSec),
    .warn     (warn)
  );

  // calendar counting with carries, then window writes on top
  always_comb begin
    next_timeReg = timeReg;
    if (secTick) begin
      if (timeReg.sec == rtc_pkg::SEC_MAX) begin
        next_timeReg.sec = 8'h00;
        if (timeReg.min == rtc_pkg::SEC_MAX) begin
          next_timeReg.min = 8'h00;
          if (timeReg.hour == rtc_pkg::HOUR_MAX) begin
            next_timeReg.hour = 8'h00;
            next_timeReg.wday = (timeReg.wday == rtc_pkg::WDAY_MAX) ? 8'h00
                                : rtc_pkg::bcdInc(timeReg.wday);
            if (timeReg.day == rtc_pkg::lastDay(timeReg.month, timeReg.year)) begin
              next_timeReg.day = rtc_pkg::FIRST_DAY;
              if (timeReg.month == rtc_pkg::MONTH_MAX) begin
                next_timeReg.month = 8'h01;
                next_timeReg.year  = (timeReg.year == rtc_pkg::YEAR_MAX) ? 8'h00
                                     : rtc_pkg::bcdInc(timeReg.year);
              end else begin
                next_timeReg.month = rtc_pkg::bcdInc(timeReg.month);
              end
            end else begin
              next_timeReg.day = rtc_pkg::bcdInc(timeReg.day);
            end
          end else begin
            next_timeReg.hour = rtc_pkg::bcdInc(timeReg.hour);
          end
        end else begin
          next_timeReg.min = rtc_pkg::bcdInc(timeReg.min);
        end
      end else begin
        next_timeReg.sec = rtc_pkg::bcdInc(timeReg.sec);
      end
    end
    if (timeWrite) begin
      next_timeReg = rtc_pkg::winWrite(next_timeReg, tptr, wdata, byteEn);
    end
    next_alarmReg = alarmReg;
    if (wrOk && addr == rtc_pkg::ADDR_ALRMWIN) begin
      next_alarmReg = rtc_pkg::winWrite(alarmReg, aptr, wdata, byteEn);
    end
  end

  // value registers survive the external reset
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      timeReg  <= '0;
      alarmReg <= '0;
    end else begin
      timeReg  <= next_timeReg;
      alarmReg <= next_alarmReg;
    end
  end

  // alarm compare, widening with the mask code
  always_comb begin
    unique case (amask)
      rtc_pkg::AM_HALF,
      rtc_pkg::AM_SEC:   match = 1'b1;
      rtc_pkg::AM_10S:   match = timeReg.sec[3:0] == alarmReg.sec[3:0];
      rtc_pkg::AM_MIN:   match = timeReg.sec == alarmReg.sec;
      rtc_pkg::AM_10M:   match = timeReg.sec == alarmReg.sec
                                 && timeReg.min[3:0] == alarmReg.min[3:0];
      rtc_pkg::AM_HOUR:  match = timeReg[15:0] == alarmReg[15:0];
      rtc_pkg::AM_DAY:   match = timeReg[23:0] == alarmReg[23:0];
      rtc_pkg::AM_WEEK:  match = timeReg[31:0] == alarmReg[31:0];
      rtc_pkg::AM_MONTH: match = timeReg[23:0] == alarmReg[23:0]
                                 && timeReg.day == alarmReg.day;
      rtc_pkg::AM_YEAR:  match = timeReg[23:0] == alarmReg[23:0]
                                 && timeReg.day == alarmReg.day
                                 && timeReg.month == alarmReg.month;
      default:           match = 1'b0;
    endcase
  end

  assign alarmEvent = alCfg[rtc_pkg::AL_EN] && match
                      && (secTick || (halfTick && amask == rtc_pkg::AM_HALF));

  // control registers, pointers, repeat counter and read data
  always_comb begin
    next_cfg            = cfg;
    next_srcSel         = srcSel;
    next_alCfg          = alCfg;
    next_rdata          = 16'h0000;
    next_alarmToggle    = alarmToggle;
    next_alarmEventFlag = alarmEvent;
    if (alarmEvent) begin
      next_alarmToggle = !alarmToggle;
      if (rpt != rtc_pkg::RPT_ZERO) begin
        next_alCfg[7:0] = 8'(rpt - 1'b1);
      end else if (alCfg[rtc_pkg::AL_CHIME]) begin
        next_alCfg[7:0] = rtc_pkg::RPT_FULL;
      end else begin
        next_alCfg[rtc_pkg::AL_EN] = 1'b0;
      end
    end
    if (wrOk) begin
      unique case (addr)
        rtc_pkg::ADDR_CONFIG: begin
          next_cfg = {cfg[rtc_pkg::CFG_EN], 1'b0, wdata[rtc_pkg::CFG_UNLOCK], 2'b00,
                      wdata[rtc_pkg::CFG_OE:0]};
          if (cfg[rtc_pkg::CFG_UNLOCK]) begin
            next_cfg[rtc_pkg::CFG_EN] = wdata[rtc_pkg::CFG_EN];
          end
        end
        rtc_pkg::ADDR_PAD:   next_srcSel = wdata[rtc_pkg::PAD_SRCSEL];
        rtc_pkg::ADDR_ALCFG: next_alCfg = wdata;
        rtc_pkg::ADDR_TIMEWIN: begin
          if (byteEn[1] && tptr != rtc_pkg::PTR_MINSEC) begin
            next_cfg[rtc_pkg::PTR_HI:rtc_pkg::PTR_LO] = 2'(tptr - 1'b1);
          end
        end
        rtc_pkg::ADDR_ALRMWIN: begin
          if (byteEn[1] && aptr != rtc_pkg::PTR_MINSEC) begin
            next_alCfg[rtc_pkg::PTR_HI:rtc_pkg::PTR_LO] = 2'(aptr - 1'b1);
          end
        end
        default: ;
      endcase
    end
    if (rdOk) begin
      unique case (addr)
        rtc_pkg::ADDR_CONFIG: begin
          next_rdata = cfg;
          next_rdata[rtc_pkg::CFG_WARN] = warn;
          next_rdata[rtc_pkg::CFG_HALF] = halfSec;
        end
        rtc_pkg::ADDR_PAD:   next_rdata[rtc_pkg::PAD_SRCSEL] = srcSel;
        rtc_pkg::ADDR_ALCFG: next_rdata = alCfg;
        rtc_pkg::ADDR_TIMEWIN: begin
          next_rdata = rtc_pkg::winRead(timeReg, tptr);
          if (tptr != rtc_pkg::PTR_MINSEC) begin
            next_cfg[rtc_pkg::PTR_HI:rtc_pkg::PTR_LO] = 2'(tptr - 1'b1);
          end
        end
        rtc_pkg::ADDR_ALRMWIN: begin
          next_rdata = rtc_pkg::winRead(alarmReg, aptr);
          if (aptr != rtc_pkg::PTR_MINSEC) begin
            next_alCfg[rtc_pkg::PTR_HI:rtc_pkg::PTR_LO] = 2'(aptr - 1'b1);
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cfg            <= 16'h0000;
      srcSel         <= 1'b0;
      alCfg          <= 16'h0000;
      rdata          <= 16'h0000;
      alarmToggle    <= 1'b0;
      alarmEventFlag <= 1'b0;
    end else begin
      cfg            <= next_cfg;
      srcSel         <= next_srcSel;
      alCfg          <= next_alCfg;
      rdata          <= next_rdata;
      alarmToggle    <= next_alarmToggle;
      alarmEventFlag <= next_alarmEventFlag;
    end
  end

  // pin shows 1 Hz clock or alarm toggle, only when enabled
  assign rtcPinOe  = cfg[rtc_pkg::CFG_OE];
  assign rtcPinOut = cfg[rtc_pkg::CFG_OE] && (srcSel ? !halfSec : alarmToggle);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  a_hour_range: assert property (timeReg.hour <= rtc_pkg::HOUR_MAX)
    else $error("hour left 00..23");
  a_year_digits: assert property (timeReg.year[7:4] <= 4'h9 && timeReg.year[3:0] <= 4'h9)
    else $error("year not BCD");
  a_sec_advance: assert property (secTick && !timeWrite |=> timeReg.sec != $past(timeReg.sec))
    else $error("second did not advance on tick");
  a_time_hold: assert property (!secTick && !timeWrite |=> $stable(timeReg))
    else $error("time changed without tick");
  a_time_lock: assert property (wr && addr == rtc_pkg::ADDR_TIMEWIN && !cfg[rtc_pkg::CFG_UNLOCK]
                                && !secTick |=> $stable(timeReg))
    else $error("locked time window was written");
  a_tptr_read: assert property (rdOk && addr == rtc_pkg::ADDR_TIMEWIN && tptr != 2'h0
                                |=> tptr == $past(tptr) - 2'h1)
    else $error("time pointer did not step on read");
  a_tptr_floor: assert property (rdOk && addr == rtc_pkg::ADDR_TIMEWIN && tptr == 2'h0
                                 |=> tptr == 2'h0)
    else $error("time pointer left floor");
  a_aptr_lower: assert property (wrOk && addr == rtc_pkg::ADDR_ALRMWIN && !byteEn[1]
                                 |=> $stable(aptr))
    else $error("alarm pointer moved on lower write");
  a_repeat_stop: assert property (alarmEvent && rpt == 8'h00 && !alCfg[rtc_pkg::AL_CHIME]
                                  && !(wrOk && addr == rtc_pkg::ADDR_ALCFG)
                                  |=> rpt == 8'h00 && !alCfg[rtc_pkg::AL_EN])
    else $error("repeat end did not disable alarm");
  a_pin_gate: assert property (!rtcPinOe |-> !rtcPinOut)
    else $error("pin driven while output disabled");
  a_alarm_pulse: assert property (alarmEvent |=> alarmEventFlag && alarmToggle != $past(alarmToggle))
    else $error("alarm event not reported");

  // pointer steps, repeat counting, day wrap and the locked enable bit
  a_tptr_write: assert property (wrOk && addr == rtc_pkg::ADDR_TIMEWIN && byteEn[1]
    && tptr != rtc_pkg::PTR_MINSEC |=> tptr == $past(tptr) - 2'h1)
    else $error("time pointer did not step on upper write");
  a_aptr_read: assert property (rdOk && addr == rtc_pkg::ADDR_ALRMWIN
    && aptr != rtc_pkg::PTR_MINSEC |=> aptr == $past(aptr) - 2'h1)
    else $error("alarm pointer did not step on read");
  a_aptr_floor: assert property ((rdOk || wrOk) && addr == rtc_pkg::ADDR_ALRMWIN
    && aptr == rtc_pkg::PTR_MINSEC |=> aptr == rtc_pkg::PTR_MINSEC)
    else $error("alarm pointer left floor");
  a_repeat_step: assert property (alarmEvent && rpt != rtc_pkg::RPT_ZERO
    && !(wrOk && addr == rtc_pkg::ADDR_ALCFG) |=> rpt == $past(rpt) - 8'h01)
    else $error("repeat count did not step down");
  a_chime_roll: assert property (alarmEvent && rpt == rtc_pkg::RPT_ZERO
    && alCfg[rtc_pkg::AL_CHIME] && !(wrOk && addr == rtc_pkg::ADDR_ALCFG)
    |=> rpt == rtc_pkg::RPT_FULL)
    else $error("chime did not wrap repeat count");
  a_hour_wrap: assert property (secTick && !timeWrite
    && timeReg.hour == rtc_pkg::HOUR_MAX && timeReg.min == rtc_pkg::SEC_MAX
    && timeReg.sec == rtc_pkg::SEC_MAX |=> timeReg.hour == 8'h00)
    else $error("hour did not wrap to 00");
  a_enable_lock: assert property (wrOk && addr == rtc_pkg::ADDR_CONFIG
    && !cfg[rtc_pkg::CFG_UNLOCK] |=> $stable(cfg[rtc_pkg::CFG_EN]))
    else $error("enable changed while locked");
  a_flag_cause: assert property (alarmEventFlag |-> $past(alarmEvent))
    else $error("alarm flag without event");

  c_alarm_fire: cover property (alarmEvent);
  c_chime_wrap: cover property (alarmEvent && rpt == 8'h00 && alCfg[rtc_pkg::AL_CHIME]);
  c_day_roll: cover property (secTick && timeReg[23:0] == 24'h235959);
  c_ptr_walk: cover property (rdOk && addr == rtc_pkg::ADDR_TIMEWIN && tptr == 2'h3);

endmodule : calendar_clock_unit

// file: verilog/rtc_pkg.sv
// What this block does
// - hours count 00 to 23, no AM/PM
// - two-digit year, hundred-year span ending 2099
// - count all fields, February 29 in leap years
// - all values held in BCD, nibble per digit
// - alarm compares fields, repeats under repeat setting
// - pin square wave from alarm or 1 Hz
// - counters advance once per second with carries
// - clock keeps counting through external reset
// - time pointer selects field pair per mapping
// - time pointer decrements on upper byte access, floors
// - alarm pointer selects field pair, same mapping
// - alarm pointer decrements on upper access, floors
// - any window read decrements its pointer
// - writes decrement only when upper byte written
// - time writes accepted only while unlocked
// - rollover warning within 32 oscillator edges
// - repeat count decrements, chime wraps, enable self-clears
// - source select routes pin, gated by output enable
package rtc_pkg;

  // register indices on the plain bus
  localparam logic [2:0] ADDR_CONFIG  = 3'h0;
  localparam logic [2:0] ADDR_PAD     = 3'h1;
  localparam logic [2:0] ADDR_ALCFG   = 3'h2;
  localparam logic [2:0] ADDR_TIMEWIN = 3'h3;
  localparam logic [2:0] ADDR_ALRMWIN = 3'h4;

  // field positions
  localparam int CFG_EN     = 15;
  localparam int CFG_UNLOCK = 13;
  localparam int CFG_WARN   = 12;
  localparam int CFG_HALF   = 11;
  localparam int CFG_OE     = 10;
  localparam int PTR_HI     = 9;
  localparam int PTR_LO     = 8;
  localparam int PAD_SRCSEL = 1;
  localparam int AL_EN      = 15;
  localparam int AL_CHIME   = 14;
  localparam int AL_MASK_HI = 13;
  localparam int AL_MASK_LO = 10;

  // window pointer codes
  localparam logic [1:0] PTR_MINSEC = 2'h0;
  localparam logic [1:0] PTR_WDHR   = 2'h1;
  localparam logic [1:0] PTR_MTHDAY = 2'h2;
  localparam logic [1:0] PTR_YEAR   = 2'h3;

  // BCD limits and implemented bits per field
  localparam logic [7:0] SEC_MAX   = 8'h59;
  localparam logic [7:0] HOUR_MAX  = 8'h23;
  localparam logic [7:0] WDAY_MAX  = 8'h06;
  localparam logic [7:0] MONTH_MAX = 8'h12;
  localparam logic [7:0] YEAR_MAX  = 8'h99;
  localparam logic [7:0] FIRST_DAY = 8'h01;
  localparam logic [7:0] MSK_SEC   = 8'h7F;
  localparam logic [7:0] MSK_HOUR  = 8'h3F;
  localparam logic [7:0] MSK_WDAY  = 8'h07;
  localparam logic [7:0] MSK_DAY   = 8'h3F;
  localparam logic [7:0] MSK_MONTH = 8'h1F;
  localparam logic [7:0] RPT_ZERO  = 8'h00;
  localparam logic [7:0] RPT_FULL  = 8'hFF;

  // alarm mask codes
  localparam logic [3:0] AM_HALF  = 4'h0;
  localparam logic [3:0] AM_SEC   = 4'h1;
  localparam logic [3:0] AM_10S   = 4'h2;
  localparam logic [3:0] AM_MIN   = 4'h3;
  localparam logic [3:0] AM_10M   = 4'h4;
  localparam logic [3:0] AM_HOUR  = 4'h5;
  localparam logic [3:0] AM_DAY   = 4'h6;
  localparam logic [3:0] AM_WEEK  = 4'h7;
  localparam logic [3:0] AM_MONTH = 4'h8;
  localparam logic [3:0] AM_YEAR  = 4'h9;

  // oscillator edges per second and warning lead
  localparam int PRESCALE_EDGES = 32768;
  localparam int WARN_EDGES     = 32;

  typedef struct packed {
    logic [7:0] year;
    logic [7:0] month;
    logic [7:0] day;
    logic [7:0] wday;
    logic [7:0] hour;
    logic [7:0] min;
    logic [7:0] sec;
  } time_s;

  // BCD increment of one two-digit byte
  function automatic logic [7:0] bcdInc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      bcdInc = {4'(v[7:4] + 4'h1), 4'h0};
    end else begin
      bcdInc = {v[7:4], 4'(v[3:0] + 4'h1)};
    end
  endfunction : bcdInc

  // last day of month in BCD, leap years every fourth year
  function automatic logic [7:0] lastDay(input logic [7:0] month, input logic [7:0] year);
    logic leap;
    leap = year[4] ? (year[3:0] == 4'h2 || year[3:0] == 4'h6)
                   : (year[3:0] == 4'h0 || year[3:0] == 4'h4 || year[3:0] == 4'h8);
    case (month)
      8'h02:                      lastDay = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: lastDay = 8'h30;
      default:                    lastDay = 8'h31;
    endcase
  endfunction : lastDay

  // word seen through a window at a pointer value
  function automatic logic [15:0] winRead(input time_s t, input logic [1:0] ptr);
    case (ptr)
      PTR_MINSEC: winRead = {t.min, t.sec};
      PTR_WDHR:   winRead = {t.wday, t.hour};
      PTR_MTHDAY: winRead = {t.month, t.day};
      default:    winRead = {8'h00, t.year};
    endcase
  endfunction : winRead

  // byte-lane write through a window
  function automatic time_s winWrite(input time_s t, input logic [1:0] ptr,
                                     input logic [15:0] d, input logic [1:0] be);
    winWrite = t;
    case (ptr)
      PTR_MINSEC: begin
        if (be[1]) winWrite.min = d[15:8] & MSK_SEC;
        if (be[0]) winWrite.sec = d[7:0] & MSK_SEC;
      end
      PTR_WDHR: begin
        if (be[1]) winWrite.wday = d[15:8] & MSK_WDAY;
        if (be[0]) winWrite.hour = d[7:0] & MSK_HOUR;
      end
      PTR_MTHDAY: begin
        if (be[1]) winWrite.month = d[15:8] & MSK_MONTH;
        if (be[0]) winWrite.day = d[7:0] & MSK_DAY;
      end
      default: begin
        if (be[0]) winWrite.year = d[7:0];
      end
    endcase
  endfunction : winWrite

endpackage : rtc_pkg

// file: verilog/rtc_prescaler.sv
`timescale 1ns/1ns
// divides the secondary oscillator down to second and half-second ticks
module rtc_prescaler #(
  parameter int PRESCALE = rtc_pkg::PRESCALE_EDGES  // oscillator edges per second
) (
  input  wire logic sys_clk,   // system clock
  input  wire logic nrst,      // power-on reset, active low
  input  wire logic oscClk,    // secondary oscillator level
  input  wire logic run,       // counting enabled
  input  wire logic clear,     // restart the second
  output logic      secTick,   // pulse at end of second
  output logic      halfTick,  // pulse at mid second
  output logic      halfSec,   // second half of the second
  output logic      warn       // rollover close
);
  localparam int W = $clog2(PRESCALE);
  localparam logic [W-1:0] LAST = W'(PRESCALE - 1);
  localparam logic [W-1:0] HALF = W'(PRESCALE / 2);
  localparam logic [W-1:0] WARN = W'(PRESCALE - rtc_pkg::WARN_EDGES);

  logic         oscPrev;
  logic [W-1:0] count;
  logic [W-1:0] next_count;
  logic         oscEdge;

  assign oscEdge = oscClk && !oscPrev;

  // count oscillator rising edges, wrap once per second
  always_comb begin
    next_count = count;
    if (clear) begin
      next_count = '0;
    end else if (run && oscEdge) begin
      next_count = (count == LAST) ? '0 : W'(count + 1'b1);
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      oscPrev <= 1'b0;
      count   <= '0;
    end else begin
      oscPrev <= oscClk;
      count   <= next_count;
    end
  end

  // ticks are single cycles, secTick on the wrapping edge and halfTick on the edge into the second half
  assign secTick  = !clear && run && oscEdge && (count == LAST);
  assign halfTick = !clear && run && oscEdge && (count == HALF - 1'b1);
  assign halfSec  = (count >= HALF);
  assign warn     = run && (count >= WARN);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  a_tick_wraps: assert property (secTick |=> count == '0)
    else $error("second tick without counter wrap");
  a_warn_before: assert property (secTick |-> warn)
    else $error("rollover warning missing at tick");

endmodule : rtc_prescaler
